// *** common/jtdbg_map.svh ***
// constants of the test access port and the debug event line
`ifndef JTDBG_MAP_SVH
`define JTDBG_MAP_SVH

`define JTDBG_IR_W 4
`define JTDBG_DR_W 32
`define JTDBG_IR_CAPTURE 4'h1
`define JTDBG_IR_IDCODE 4'h2
`define JTDBG_IR_STATUS 4'h3
`define JTDBG_IR_BYPASS 4'hF
`define JTDBG_IDCODE_DEF 32'h0000_1001
`define JTDBG_TLR_RUN 5
`define JTDBG_SYNC_STAGES 2

`endif

// *** common/jtdbg_pkg.sv ***
// types shared by the test access port and debug event logic
package jtdbg_pkg;

   typedef enum logic [3:0] {
      TAP_RESET, TAP_IDLE,
      TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
      TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR,
      TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR,
      TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
   } jtdbg_tap_state_t;

   // one driven pin: level and enable
   typedef struct packed {
      logic out;
      logic oe;
   } jtdbg_pin_drive_t;

   // pull-up enables of data in, mode select, test reset and the debug event line
   typedef struct packed {
      logic tdi;
      logic tms;
      logic trst;
      logic debug_event_line;
   } jtdbg_pullup_t;

endpackage

// *** rtl/jtdbg_port.sv ***
// test access port controller with open-drain debug event line
//
// Contract
// - capture test data in on rising clock
// - sample mode select on rising clock edge
// - test data out changes on falling edge
// - drive data out only in shift states
// - test reset low resets controller asynchronously
// - pull-ups on data in, mode, reset
// - low debug line requests debug mode
// - device pulls debug line low in debug
// - debug line open-drain, input during reset
`timescale 1ns/1ps
`include "jtdbg_map.svh"

module jtdbg_port #(
   parameter int IR_W = `JTDBG_IR_W,
   parameter int DR_W = `JTDBG_DR_W,
   // identity value is arbitrary
   parameter logic [DR_W-1:0] IDCODE = `JTDBG_IDCODE_DEF
) (
   input wire logic core_clk, // system clock, 50 MHz
   input wire logic rstn, // system reset, active low
   input wire logic tck, // test clock from the controller
   input wire logic trst_n, // test reset, active low
   input wire logic tms, // test mode select
   input wire logic tdi, // test data in
   output jtdbg_pkg::jtdbg_pin_drive_t tdo, // test data out and its enable
   input wire logic debug_event_line_in, // level seen on the debug line
   output jtdbg_pkg::jtdbg_pin_drive_t debug_event_line, // debug line pull-down
   output jtdbg_pkg::jtdbg_pullup_t pullup_en, // pull-up enables
   input wire logic debug_exit, // core leaves debug mode, one-cycle pulse
   output logic debug_mode // chip is in debug mode
);

   // refused at elaboration: the instruction decode is fixed at four bits
   if (IR_W != `JTDBG_IR_W || DR_W < 2) begin : g_width_check
      $error("jtdbg_port: unsupported register widths");
   end

   ////////////////////////////////////////////////////////////////////////
   // core domain: debug event line

   logic [`JTDBG_SYNC_STAGES-1:0] de_sync_reg;
   logic debug_mode_reg;
   logic wait_release_reg;
   logic de_oe_reg;
   jtdbg_pkg::jtdbg_pullup_t pullup_reg;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         de_sync_reg <= '1;
      end else begin
         de_sync_reg <= {de_sync_reg[0], debug_event_line_in};
      end
   end

   // after release the line stays low in the synchroniser for a while;
   // blanking until it reads high stops a false re-entry
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         debug_mode_reg <= 1'b0;
         wait_release_reg <= 1'b0;
      end else if (debug_mode_reg) begin
         if (debug_exit) begin
            debug_mode_reg <= 1'b0;
            wait_release_reg <= 1'b1;
         end
      end else if (wait_release_reg) begin
         if (de_sync_reg[1]) begin
            wait_release_reg <= 1'b0;
         end
      end else if (!de_sync_reg[1]) begin
         debug_mode_reg <= 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         de_oe_reg <= 1'b0;
      end else begin
         de_oe_reg <= debug_mode_reg && !debug_exit;
      end
   end

   // pull-ups stay on at all times, reset included
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         pullup_reg <= '1;
      end else begin
         pullup_reg <= '1;
      end
   end

   always_comb begin
      debug_event_line.out = 1'b0;
      debug_event_line.oe = de_oe_reg;
   end
   assign debug_mode = debug_mode_reg;
   assign pullup_en = pullup_reg;

   ////////////////////////////////////////////////////////////////////////
   // test clock domain: controller

   jtdbg_pkg::jtdbg_tap_state_t state_reg;
   jtdbg_pkg::jtdbg_tap_state_t state_next;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         jtdbg_pkg::TAP_RESET: begin
            state_next = tms ? jtdbg_pkg::TAP_RESET : jtdbg_pkg::TAP_IDLE;
         end
         jtdbg_pkg::TAP_IDLE: begin
            state_next = tms ? jtdbg_pkg::TAP_SEL_DR : jtdbg_pkg::TAP_IDLE;
         end
         jtdbg_pkg::TAP_SEL_DR: begin
            state_next = tms ? jtdbg_pkg::TAP_SEL_IR : jtdbg_pkg::TAP_CAP_DR;
         end
         jtdbg_pkg::TAP_CAP_DR: begin
            state_next = tms ? jtdbg_pkg::TAP_EXIT1_DR : jtdbg_pkg::TAP_SHIFT_DR;
         end
         jtdbg_pkg::TAP_SHIFT_DR: begin
            state_next = tms ? jtdbg_pkg::TAP_EXIT1_DR : jtdbg_pkg::TAP_SHIFT_DR;
         end
         jtdbg_pkg::TAP_EXIT1_DR: begin
            state_next = tms ? jtdbg_pkg::TAP_UPD_DR : jtdbg_pkg::TAP_PAUSE_DR;
         end
         jtdbg_pkg::TAP_PAUSE_DR: begin
            state_next = tms ? jtdbg_pkg::TAP_EXIT2_DR : jtdbg_pkg::TAP_PAUSE_DR;
         end
         jtdbg_pkg::TAP_EXIT2_DR: begin
            state_next = tms ? jtdbg_pkg::TAP_UPD_DR : jtdbg_pkg::TAP_SHIFT_DR;
         end
         jtdbg_pkg::TAP_UPD_DR: begin
            state_next = tms ? jtdbg_pkg::TAP_SEL_DR : jtdbg_pkg::TAP_IDLE;
         end
         jtdbg_pkg::TAP_SEL_IR: begin
            state_next = tms ? jtdbg_pkg::TAP_RESET : jtdbg_pkg::TAP_CAP_IR;
         end
         jtdbg_pkg::TAP_CAP_IR: begin
            state_next = tms ? jtdbg_pkg::TAP_EXIT1_IR : jtdbg_pkg::TAP_SHIFT_IR;
         end
         jtdbg_pkg::TAP_SHIFT_IR: begin
            state_next = tms ? jtdbg_pkg::TAP_EXIT1_IR : jtdbg_pkg::TAP_SHIFT_IR;
         end
         jtdbg_pkg::TAP_EXIT1_IR: begin
            state_next = tms ? jtdbg_pkg::TAP_UPD_IR : jtdbg_pkg::TAP_PAUSE_IR;
         end
         jtdbg_pkg::TAP_PAUSE_IR: begin
            state_next = tms ? jtdbg_pkg::TAP_EXIT2_IR : jtdbg_pkg::TAP_PAUSE_IR;
         end
         jtdbg_pkg::TAP_EXIT2_IR: begin
            state_next = tms ? jtdbg_pkg::TAP_UPD_IR : jtdbg_pkg::TAP_SHIFT_IR;
         end
         jtdbg_pkg::TAP_UPD_IR: begin
            state_next = tms ? jtdbg_pkg::TAP_SEL_DR : jtdbg_pkg::TAP_IDLE;
         end
      endcase
   end

   always_ff @(posedge tck or negedge trst_n) begin
      if (!trst_n) begin
         state_reg <= jtdbg_pkg::TAP_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // test clock domain: instruction and data registers

   logic [IR_W-1:0] ir_shift_reg;
   logic [IR_W-1:0] ir_reg;
   logic [DR_W-1:0] dr_shift_reg;
   logic bypass_reg;
   logic [`JTDBG_SYNC_STAGES-1:0] dbg_sync_reg;

   // debug mode is a level, so two flops suffice; the test clock may
   // stand still, which only delays what the status register shows
   always_ff @(posedge tck or negedge trst_n) begin
      if (!trst_n) begin
         dbg_sync_reg <= '0;
      end else begin
         dbg_sync_reg <= {dbg_sync_reg[0], debug_mode_reg};
      end
   end

   always_ff @(posedge tck or negedge trst_n) begin
      if (!trst_n) begin
         ir_shift_reg <= '0;
         ir_reg <= `JTDBG_IR_IDCODE;
      end else begin
         unique case (state_reg)
            jtdbg_pkg::TAP_RESET: ir_reg <= `JTDBG_IR_IDCODE;
            jtdbg_pkg::TAP_CAP_IR: ir_shift_reg <= `JTDBG_IR_CAPTURE;
            jtdbg_pkg::TAP_SHIFT_IR: ir_shift_reg <= {tdi, ir_shift_reg[IR_W-1:1]};
            jtdbg_pkg::TAP_UPD_IR: ir_reg <= ir_shift_reg;
            default: ;
         endcase
      end
   end

   always_ff @(posedge tck or negedge trst_n) begin
      if (!trst_n) begin
         dr_shift_reg <= '0;
         bypass_reg <= 1'b0;
      end else if (state_reg == jtdbg_pkg::TAP_CAP_DR) begin
         bypass_reg <= 1'b0;
         if (ir_reg == `JTDBG_IR_IDCODE) begin
            dr_shift_reg <= IDCODE;
         end else begin
            dr_shift_reg <= {{(DR_W-1){1'b0}}, dbg_sync_reg[1]};
         end
      end else if (state_reg == jtdbg_pkg::TAP_SHIFT_DR) begin
         bypass_reg <= tdi;
         dr_shift_reg <= {tdi, dr_shift_reg[DR_W-1:1]};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // test clock domain: data out on the falling edge

   logic tdo_reg;
   logic tdo_oe_reg;
   logic dr_bit;

   // unknown instructions select the one-bit bypass path
   always_comb begin
      if (ir_reg == `JTDBG_IR_IDCODE || ir_reg == `JTDBG_IR_STATUS) begin
         dr_bit = dr_shift_reg[0];
      end else begin
         dr_bit = bypass_reg;
      end
   end

   always_ff @(negedge tck or negedge trst_n) begin
      if (!trst_n) begin
         tdo_reg <= 1'b0;
         tdo_oe_reg <= 1'b0;
      end else begin
         tdo_oe_reg <= state_reg == jtdbg_pkg::TAP_SHIFT_IR
                       || state_reg == jtdbg_pkg::TAP_SHIFT_DR;
         if (state_reg == jtdbg_pkg::TAP_SHIFT_IR) begin
            tdo_reg <= ir_shift_reg[0];
         end else if (state_reg == jtdbg_pkg::TAP_SHIFT_DR) begin
            tdo_reg <= dr_bit;
         end
      end
   end

   always_comb begin
      tdo.out = tdo_reg;
      tdo.oe = tdo_oe_reg;
   end

endmodule

// *** verif/jtdbg_port_assertions.sv ***
// concurrent checks on the test port and debug line pins
`timescale 1ns/1ps
module jtdbg_port_assertions (
   input wire logic core_clk, // system clock
   input wire logic rstn, // system reset
   input wire logic tck, // test clock
   input wire logic trst_n, // test reset
   input wire logic tms, // mode select
   input wire logic tdi, // data in
   input jtdbg_pkg::jtdbg_pin_drive_t tdo, // data out
   input wire logic debug_event_line_in, // line level
   input jtdbg_pkg::jtdbg_pin_drive_t debug_event_line, // line pull
   input jtdbg_pkg::jtdbg_pullup_t pullup_en, // pull-ups
   input wire logic debug_exit, // exit pulse
   input wire logic debug_mode // debug flag
);
   jtdbg_pkg::jtdbg_pin_drive_t tdo_pos;
   // value held over the high half; a change there means a rising-edge update
   always_ff @(posedge tck or negedge trst_n) begin
      if (!trst_n) begin
         tdo_pos <= '0;
      end else begin
         tdo_pos <= tdo;
      end
   end
   sequence req_s;
      !debug_mode && $fell(debug_event_line_in) ##1 !debug_event_line_in [*2];
   endsequence
   a_tdo_fall_only: assert property (@(negedge tck) disable iff (!trst_n) tdo == tdo_pos)
      else $error("data out moved while clock high");
   a_oe_enter_shift: assert property (@(negedge tck) disable iff (!trst_n)
      $rose(tdo.oe) |-> !$past(tms)) else $error("data out enabled off shift entry");
   a_oe_leave_shift: assert property (@(negedge tck) disable iff (!trst_n)
      tdo.oe && tms |=> !tdo.oe) else $error("data out enabled after shift exit");
   a_trst_async: assert property (@(posedge core_clk) disable iff (!rstn)
      !trst_n |-> !tdo.oe) else $error("data out driven in test reset");
   a_debug_enter: assert property (@(posedge core_clk) disable iff (!rstn)
      req_s |-> ##1 debug_mode ##1 debug_event_line.oe) else $error("debug request missed");
   a_ack_hold: assert property (@(posedge core_clk) disable iff (!rstn)
      debug_mode && !debug_exit |=> debug_mode) else $error("debug mode dropped");
   a_exit_drop: assert property (@(posedge core_clk) disable iff (!rstn)
      debug_mode && debug_exit |=> !debug_mode && !debug_event_line.oe)
      else $error("debug exit ignored");
   a_line_open_drain: assert property (@(posedge core_clk) disable iff (!rstn)
      debug_event_line.oe |-> !debug_event_line.out && debug_mode)
      else $error("debug line driven wrongly");
   a_pullups_on: assert property (@(posedge core_clk) disable iff (!rstn)
      pullup_en == 4'hF) else $error("pull-up disabled");
endmodule
bind jtdbg_port jtdbg_port_assertions u_jtdbg_port_assertions (.core_clk(core_clk),
   .rstn(rstn), .tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi), .tdo(tdo),
   .debug_event_line_in(debug_event_line_in), .debug_event_line(debug_event_line),
   .pullup_en(pullup_en), .debug_exit(debug_exit), .debug_mode(debug_mode));

// *** verif/jtdbg_ctrl_model.sv ***
// far-side test controller: test clock, mode, data, reset and debug pull
`timescale 1ns/1ps
module jtdbg_ctrl_model (
   output logic tck, // test clock
   output logic tms, // mode select
   output logic tdi, // data in
   output logic trst_n, // test reset
   output logic pull_n, // debug line pull, active low
   input wire logic tdo_out, // data out
   input wire logic tdo_oe // data out enable
);
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
      trst_n = 1'b0;
      pull_n = 1'b1;
   end
   // clock runs only inside a step, so it stands still between frames
   task automatic step(input logic m, input logic d, output logic q);
      tms = m;
      tdi = d;
      #16;
      q = tdo_oe ? tdo_out : ~tdo_out;
      tck = 1'b1;
      #32;
      tck = 1'b0;
      #16;
   endtask
   task automatic scan(input int n, input logic [31:0] din, output logic [31:0] dout);
      dout = '0;
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], dout[i]);
      end
   endtask
   task automatic hold_reset(input logic on);
      trst_n = !on;
   endtask
   task automatic request(input logic on);
      pull_n = !on;
   endtask
endmodule

// *** verif/jtdbg_port_bench.sv ***
// bench for the test port and debug line
`timescale 1ns/1ps
module jtdbg_port_bench;
   localparam logic [31:0] ID = 32'h0000_5A3C; // arbitrary identity
   logic core_clk, rstn, debug_exit, tck, tms, tdi, trst_n, pull_n, debug_mode, line, b;
   jtdbg_pkg::jtdbg_pin_drive_t tdo, dl;
   jtdbg_pkg::jtdbg_pullup_t pu;
   logic [31:0] q;
   int fail_count = 0;
   int compares = 0;
   assign line = !(dl.oe && !dl.out) && pull_n && pu.debug_event_line;
   jtdbg_port #(.IDCODE(ID)) u_jtdbg_port (.core_clk(core_clk), .rstn(rstn), .tck(tck),
      .trst_n(trst_n), .tms(tms), .tdi(tdi), .tdo(tdo), .debug_event_line_in(line),
      .debug_event_line(dl), .pullup_en(pu), .debug_exit(debug_exit), .debug_mode(debug_mode));
   jtdbg_ctrl_model u_jtdbg_ctrl_model (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
      .pull_n(pull_n), .tdo_out(tdo.out), .tdo_oe(tdo.oe));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // mode select bits are sent lsb first
   task automatic walk(input logic [15:0] m, input int n);
      for (int i = 0; i < n; i++) begin
         u_jtdbg_ctrl_model.step(m[i], 1'b0, b);
      end
   endtask
   task automatic read_id(input logic [15:0] m, input int n);
      walk(m, n);
      u_jtdbg_ctrl_model.scan(32, 32'h0, q);
      check(q, ID);
      walk(16'h0001, 2);
   endtask
   task automatic t_ir_bypass;
      walk(16'h0003, 4);
      u_jtdbg_ctrl_model.scan(4, 32'hF, q);
      check(q[3:0], 4'h1);
      walk(16'h0003, 4);
      u_jtdbg_ctrl_model.scan(3, 32'h5, q);
      check(q[2:0], 3'b010);
   endtask
   task automatic t_async_reset;
      walk(16'h0001, 3);
      check(tdo.oe, 1'b1);
      u_jtdbg_ctrl_model.hold_reset(1'b1);
      #5;
      check(tdo.oe, 1'b0);
      u_jtdbg_ctrl_model.hold_reset(1'b0);
   endtask
   task automatic t_debug;
      int i;
      u_jtdbg_ctrl_model.request(1'b1);
      for (i = 0; i < 20 && debug_mode !== 1'b1; i++) begin
         @(posedge core_clk);
         #1;
      end
      check(debug_mode, 1'b1);
      if (i == 20) begin
         give_verdict;
      end
      repeat (2) @(posedge core_clk);
      #1;
      check(dl.oe, 1'b1);
      // status instruction shows debug mode across the test clock domain
      walk(16'h0006, 5);
      u_jtdbg_ctrl_model.scan(4, 32'h3, q);
      check(q, 32'h1);
      walk(16'h0003, 4);
      u_jtdbg_ctrl_model.scan(32, 32'h0, q);
      check(q, 32'h1);
      walk(16'h0001, 2);
      u_jtdbg_ctrl_model.request(1'b0);
      repeat (4) @(posedge core_clk);
      check(line, 1'b0);
      debug_exit <= 1'b1;
      @(posedge core_clk);
      debug_exit <= 1'b0;
      #1;
      check({debug_mode, dl.oe, line}, 3'b001);
      // the synchroniser still holds the low level; blanking must stop re-entry
      repeat (4) @(posedge core_clk);
      #1;
      check(debug_mode, 1'b0);
   endtask
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   initial begin
      rstn = 1'b0;
      debug_exit = 1'b0;
      repeat (10) @(posedge core_clk);
      rstn <= 1'b1;
      #1;
      check({dl.oe, debug_mode, tdo.oe}, 3'b000);
      @(posedge core_clk);
      #1;
      check(pu, 4'hF);
      u_jtdbg_ctrl_model.hold_reset(1'b0);
      read_id(16'h0002, 4);
      t_ir_bypass;
      read_id(16'h005F, 9);
      t_async_reset;
      t_debug;
      give_verdict;
   end
endmodule
